// ---- pkg/pbsp_regs.svh ----
// Purpose: Constants for the pipelined burst SRAM port.
// Assumes: Included by the package and the design files.
// Notes: Widths, depths and reset values only.
`ifndef PBSP_REGS_SVH
`define PBSP_REGS_SVH
`define PBSP_ADDR_W 16
`define PBSP_DATA_W 32
`define PBSP_MEM_DEPTH 65536
`define PBSP_FIFO_DEPTH 32
`define PBSP_BURST_RST 2'h0
`define PBSP_DATA_RST 32'h0000_0000
`define PBSP_ADDR_RST 16'h0000
`endif

// ---- pkg/pbsp_pkg.sv ----
// Purpose: Types shared by the burst SRAM port.
// Assumes: pbsp_regs.svh holds the widths.
// Notes: No constants of its own.
`include "pbsp_regs.svh"
package pbsp_pkg;
    // Write request captured from the pins.
    typedef struct packed {
        logic [`PBSP_ADDR_W-1:0] addr;
        logic [`PBSP_DATA_W-1:0] data;
    } pbsp_wr_t;
    // Chip select group.
    typedef struct packed {
        logic sel1_n;
        logic sel2;
        logic sel3_n;
    } pbsp_sel_t;
endpackage : pbsp_pkg

// ---- hw/pbsp_fifo.sv ----
// Purpose: Parameterised valid/ready FIFO in the write data path.
// Assumes: Single clock, active-low synchronous-released reset.
// Notes: Full and empty are exact; ready low when full.
`timescale 1ns/1ps
`default_nettype none
module pbsp_fifo #(
    parameter int WIDTH = 48,
    parameter int DEPTH = 32
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Fill side.
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // Drain side.
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr_ff;
    logic [AW:0] rd_ptr_ff;
    logic do_wr;
    logic do_rd;
    // Handshakes and flags.
    assign out_valid_o = (wr_ptr_ff != rd_ptr_ff);
    assign in_ready_o = ((wr_ptr_ff - rd_ptr_ff) != (AW+1)'(DEPTH));
    assign do_wr = in_valid_i && in_ready_o;
    assign do_rd = out_valid_o && out_ready_i;
    assign out_data_o = mem[rd_ptr_ff[AW-1:0]];
    // Storage write.
    always_ff @(posedge clk_i) begin
        if (do_wr) begin
            mem[wr_ptr_ff[AW-1:0]] <= in_data_i;
        end
    end
    // Pointer update.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
        end else begin
            if (do_wr) begin
                wr_ptr_ff <= wr_ptr_ff + 1'b1;
            end
            if (do_rd) begin
                rd_ptr_ff <= rd_ptr_ff + 1'b1;
            end
        end
    end
endmodule : pbsp_fifo
`default_nettype wire

// ---- hw/pbsp_top.sv ----
// Purpose: Device side of a 64K x 32 pipelined burst SRAM port.
// Assumes: All pins come from outside and pass two flip-flops first.
// Assumes: The order strap only moves while reset is held.
// Notes: Write qualification is simplified to one write strobe input.
// Notes: Every pin is seen by the logic two edges after it is sampled.
// Notes: Read data reaches the pins two edges after the address register loads.
// Notes: Write words are queued and reach the core one cycle after the queue shows them.
// Notes: The core array is never cleared, so its contents survive sleep and reset.
// Notes: A burst ends only on a strobe seen while the device is deselected.
// Notes: Reads and writes share one burst counter; the strap picks its order.
// Overview of operation
// - Output enable low drives data pins; high releases them as inputs.
// - First read cycle after deselect keeps data pins released.
// - Burst step sampled asserted advances the burst address.
// - Processor strobe low captures address and seeds burst counter.
// - Controller strobe low captures address and seeds burst counter.
// - Both strobes low: processor strobe wins.
// - Processor strobe with chip select one high opens no access but ends a burst.
// - Sleep request stops activity and keeps memory contents.
// - Released data pins are captured into a data register each edge.
// - Read data follows the address registered one edge earlier.
// - Order strap low selects linear, high selects interleaved.
// - Burst step is active low and serves reads and writes.
// - Two-bit wrapping burst counter seeded from low address bits.
// - Interleaved order XORs start with the step count.
// - Device selected only with all three chip selects active.
`timescale 1ns/1ps
`default_nettype none
`include "pbsp_regs.svh"

module pbsp_top (
    // Clock and reset.
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    // Address and control pins.
    input wire logic [`PBSP_ADDR_W-1:0] addr_i,
    input wire logic proc_addr_strobe_n_i,
    input wire logic ctrl_addr_strobe_n_i,
    input wire logic burst_step_n_i,
    input wire pbsp_pkg::pbsp_sel_t chip_sel_i,
    input wire logic write_n_i,
    input wire logic out_en_n_i,
    input wire logic sleep_request_i,
    input wire logic burst_mode_i,
    // Data pins.
    input wire logic [`PBSP_DATA_W-1:0] dq_i,
    output logic [`PBSP_DATA_W-1:0] dq_o,
    output logic dq_oe_o,
    // Status.
    output logic sleeping_o,
    output logic wr_ready_o
);
    // ****************************************************************
    // Reset and pin synchronisers
    // ****************************************************************
    // Ten single-bit pins ride beside the address and data buses.
    localparam int SYNC_W = `PBSP_ADDR_W + `PBSP_DATA_W + 10;
    // Idle pin levels held in reset: strobes, enables and active-low selects off, sel2 high, sleep low.
    // A reset value of sleep high would flash the sleep status after every reset.
    localparam logic [SYNC_W-1:0] PINS_IDLE = {{(SYNC_W-2){1'b1}}, 2'b01};
    logic [1:0] rst_sync_ff;
    logic rst_n;
    logic [SYNC_W-1:0] meta_ff;
    logic [SYNC_W-1:0] pins_ff;
    logic [`PBSP_ADDR_W-1:0] s_addr;
    logic [`PBSP_DATA_W-1:0] s_dq;
    logic s_psn, s_csn, s_stepn, s_wrn, s_oen, s_sleep, s_mode;
    pbsp_pkg::pbsp_sel_t s_sel;

    // Reset release through two flip-flops.
    // Entry is immediate; release waits two edges so all flops leave reset together.
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_sync_ff <= 2'h0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_ff[1];

    // Two-stage capture of every pin. Only the second stage is read, so a
    // metastable first stage has a full cycle to settle before logic sees it.
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff <= PINS_IDLE;
            pins_ff <= PINS_IDLE;
        end else begin
            meta_ff <= {addr_i, dq_i, proc_addr_strobe_n_i, ctrl_addr_strobe_n_i,
                        burst_step_n_i, chip_sel_i, write_n_i, out_en_n_i,
                        sleep_request_i, burst_mode_i};
            pins_ff <= meta_ff;
        end
    end
    assign {s_addr, s_dq, s_psn, s_csn, s_stepn, s_sel, s_wrn, s_oen, s_sleep,
            s_mode} = pins_ff;

    // ****************************************************************
    // Address strobes and burst counter
    // ****************************************************************
    logic selected;
    logic proc_go;
    logic ctrl_go;
    logic start;
    logic [`PBSP_ADDR_W-1:0] addr_ff;
    logic [1:0] seed_ff;
    logic [1:0] step_ff;
    logic [1:0] nxt_step;
    logic [`PBSP_ADDR_W-1:0] cur_addr;
    logic in_burst_ff;

    // Burst address from seed and step count, per strap.
    // The seed stays put and only the step count moves, so both orders wrap alike.
    function automatic logic [1:0] burst_low(input logic [1:0] seed, input logic [1:0] step,
                                             input logic linear);
        if (linear) begin
            burst_low = seed + step;
        end else begin
            burst_low = seed ^ step;
        end
    endfunction : burst_low

    assign selected = !s_sel.sel1_n && s_sel.sel2 && !s_sel.sel3_n;
    assign proc_go = !s_psn && !s_sel.sel1_n && !s_sleep;
    assign ctrl_go = !s_csn && s_psn && !s_sleep;
    // An access opens only when a strobe is honoured and all three selects agree.
    assign start = (proc_go || ctrl_go) && selected;
    assign nxt_step = step_ff + 2'h1;
    assign cur_addr = {addr_ff[`PBSP_ADDR_W-1:2],
                       burst_low(seed_ff, step_ff, !s_mode)};

    // Address register and counter seed.
    // A start outranks a step, so a step seen on the strobe cycle is ignored.
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            addr_ff <= `PBSP_ADDR_RST;
            seed_ff <= `PBSP_BURST_RST;
            step_ff <= `PBSP_BURST_RST;
        end else if (start) begin
            addr_ff <= s_addr;
            seed_ff <= s_addr[1:0];
            step_ff <= `PBSP_BURST_RST;
        end else if (in_burst_ff && !s_stepn && !s_sleep) begin
            step_ff <= nxt_step;
        end
    end

    // Burst in progress flag; a deselect with a strobe ends it.
    // Start and end cannot meet in one cycle: one needs selection, the other its absence.
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            in_burst_ff <= 1'b0;
        end else if (start) begin
            in_burst_ff <= 1'b1;
        end else if ((!s_psn || !s_csn) && !selected) begin
            in_burst_ff <= 1'b0;
        end
    end

    // ****************************************************************
    // Access type and memory core
    // ****************************************************************
    logic is_write_ff;
    logic first_rd_ff;
    logic [`PBSP_DATA_W-1:0] mem [`PBSP_MEM_DEPTH];
    logic [`PBSP_DATA_W-1:0] din_ff;
    logic [`PBSP_DATA_W-1:0] rd_ff;
    pbsp_pkg::pbsp_wr_t wr_in;
    pbsp_pkg::pbsp_wr_t wr_out;
    logic wr_valid;
    logic fifo_ready;
    logic fifo_valid;
    logic drain_ok;
    logic wr_hit_ff;
    logic [`PBSP_ADDR_W-1:0] wr_addr_ff;

    // Write or read type latched at the start; first read after deselect.
    // The mask is one cycle long and only follows a start from outside a burst.
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            is_write_ff <= 1'b0;
            first_rd_ff <= 1'b0;
        end else begin
            if (start) begin
                is_write_ff <= !s_wrn;
            end
            first_rd_ff <= start && s_wrn && !in_burst_ff;
        end
    end

    // Capture data pins when released.
    // This register also serves as the write data register for the queue.
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            din_ff <= `PBSP_DATA_RST;
        end else if (!dq_oe_o) begin
            din_ff <= s_dq;
        end
    end

    // Write data cycle: the strobe cycle of a new access never counts as data
    // for the burst before it, or its floating bus would overwrite that word.
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            wr_hit_ff <= 1'b0;
            wr_addr_ff <= `PBSP_ADDR_RST;
        end else begin
            wr_hit_ff <= in_burst_ff && is_write_ff && !start && !s_wrn && !dq_oe_o
                         && !s_sleep;
            wr_addr_ff <= cur_addr;
        end
    end

    // Writes queue the data register with the burst address it was taken at.
    assign wr_valid = wr_hit_ff;
    assign wr_in.addr = wr_addr_ff;
    assign wr_in.data = din_ff;
    assign drain_ok = !s_sleep;

    // Write queue between the pins and the core. It only fills while sleep
    // holds the drain back; the ready status tells the host when it is full.
    pbsp_fifo #(
        .WIDTH(`PBSP_ADDR_W + `PBSP_DATA_W),
        .DEPTH(`PBSP_FIFO_DEPTH)
    ) u_wr_fifo (
        .clk_i(ref_clk_i),
        .rst_n_i(rst_n),
        .in_valid_i(wr_valid),
        .in_ready_o(fifo_ready),
        .in_data_i(wr_in),
        .out_valid_o(fifo_valid),
        .out_ready_i(drain_ok),
        .out_data_o(wr_out)
    );

    // Memory core write; contents are never cleared.
    // Sleep holds the drain, so queued words wait rather than being lost.
    always_ff @(posedge ref_clk_i) begin
        if (fifo_valid && drain_ok) begin
            mem[wr_out.addr] <= wr_out.data;
        end
    end

    // One-cycle pipelined read.
    // The read register keeps its last word while the burst writes or sleeps,
    // so the pins never show a half-updated value.
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rd_ff <= `PBSP_DATA_RST;
        end else if (in_burst_ff && !is_write_ff && !s_sleep) begin
            rd_ff <= mem[cur_addr];
        end
    end

    // ****************************************************************
    // Output drivers and status
    // ****************************************************************
    // Output enable with first-read mask and write release.
    // Data and enable launch from flip-flops so the pins never glitch; the enable
    // follows the synchronised pin, so it trails the pin by three edges.
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            dq_o <= `PBSP_DATA_RST;
            dq_oe_o <= 1'b0;
        end else begin
            dq_o <= rd_ff;
            dq_oe_o <= !s_oen && in_burst_ff && !is_write_ff && !first_rd_ff
                       && !s_sleep;
        end
    end

    // Sleep status and write back-pressure.
    // The ready flag lags the queue by one cycle, so a host should keep a spare slot.
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            sleeping_o <= 1'b0;
            wr_ready_o <= 1'b0;
        end else begin
            sleeping_o <= s_sleep;
            wr_ready_o <= fifo_ready;
        end
    end
endmodule : pbsp_top
`default_nettype wire

// ---- dv/pbsp_host_model.sv ----
// Purpose: Host side of the data pins and the burst order strap.
// Assumes: The bench chooses when the host drives and what.
// Notes: A released bus shows a level that flips every cycle.
`timescale 1ns/1ps
`default_nettype none
`include "pbsp_regs.svh"
module pbsp_host_model (
    // Clock, reset and strap choice.
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic mode_i,
    // Both drivers of the data bus.
    input wire logic [`PBSP_DATA_W-1:0] dev_data_i,
    input wire logic dev_oe_i,
    input wire logic host_oe_i,
    input wire logic [`PBSP_DATA_W-1:0] host_data_i,
    // Bus level and strap level.
    output logic [`PBSP_DATA_W-1:0] wire_o,
    output logic strap_o
);
    logic [`PBSP_DATA_W-1:0] last_ff = 32'h0;
    // Static strap: it may only move while reset holds.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            strap_o <= mode_i;
        end
    end
    // Bus level from whichever side drives it.
    assign wire_o = dev_oe_i ? dev_data_i : (host_oe_i ? host_data_i : ~last_ff);
    // Remembers the level so a floating bus keeps changing.
    always_ff @(posedge clk_i) begin
        last_ff <= wire_o;
    end
endmodule : pbsp_host_model
`default_nettype wire

// ---- dv/pbsp_properties.sv ----
// Purpose: Port assertions of the burst SRAM port.
// Assumes: Pins reach the logic two edges late.
// Notes: Bound to the top module at the foot.
`timescale 1ns/1ps
`default_nettype none
module pbsp_chk (
    // Clock and reset.
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    // Watched ports.
    input wire logic proc_addr_strobe_n_i,
    input wire logic ctrl_addr_strobe_n_i,
    input wire pbsp_pkg::pbsp_sel_t chip_sel_i,
    input wire logic write_n_i,
    input wire logic out_en_n_i,
    input wire logic sleep_request_i,
    input wire logic dq_oe_o,
    input wire logic sleeping_o
);
    // Strobe patterns that open or close an access.
    wire idle = proc_addr_strobe_n_i && ctrl_addr_strobe_n_i;
    wire desel = proc_addr_strobe_n_i && !ctrl_addr_strobe_n_i && !chip_sel_i.sel2;
    wire rd_go = !proc_addr_strobe_n_i && chip_sel_i == 3'h2 && write_n_i && !out_en_n_i;
    wire no_p = !proc_addr_strobe_n_i && chip_sel_i.sel1_n;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);
    // ****
    // Assertions
    // ****
    AST_OE_RELEASE:
        assert property (out_en_n_i [*5] |-> !dq_oe_o) else $error("driven, enable high");
    AST_OE_DRIVE:
        assert property (desel ##1 idle [*3] ##1 rd_go
            ##1 (idle && !out_en_n_i && !sleep_request_i) [*4] |-> ##[0:2] dq_oe_o)
            else $error("read data not driven");
    AST_FIRST_MASK:
        assert property (desel ##1 idle [*3] ##1 rd_go |-> !dq_oe_o [*5])
            else $error("first read cycle driven");
    AST_DESEL_QUIET:
        assert property ((desel || (!ctrl_addr_strobe_n_i && proc_addr_strobe_n_i
            && chip_sel_i != 3'h2)) ##1 idle [*5] |-> !dq_oe_o) else $error("driven, deselected");
    AST_PROC_IGNORED:
        assert property (desel ##1 idle [*3] ##1 (no_p && ctrl_addr_strobe_n_i) ##1 idle [*5]
            |-> !dq_oe_o) else $error("strobe taken, select one high");
    AST_BOTH_STROBES:
        assert property (desel ##1 idle [*3] ##1 (no_p && !ctrl_addr_strobe_n_i) ##1 idle [*5]
            |-> !dq_oe_o) else $error("controller strobe taken");
    AST_SLEEP_ENTER:
        assert property (sleep_request_i [*4] |-> sleeping_o) else $error("sleep not entered");
    AST_SLEEP_EXIT:
        assert property (!sleep_request_i [*4] |-> !sleeping_o) else $error("sleep not left");
    // Main scenarios reached.
    COV_READ: cover property (rd_go ##[1:8] dq_oe_o);
    COV_SLEEP: cover property ($rose(sleeping_o));
    COV_DESEL: cover property (desel);
endmodule : pbsp_chk
bind pbsp_top pbsp_chk i_chk (.ref_clk_i, .reset_n_i, .proc_addr_strobe_n_i,
    .ctrl_addr_strobe_n_i, .chip_sel_i, .write_n_i, .out_en_n_i, .sleep_request_i,
    .dq_oe_o, .sleeping_o);
`default_nettype wire

// ---- dv/tb_top.sv ----
// Purpose: Self-checking bench of the burst SRAM port.
// Assumes: Pins act two edges after they are driven.
// Notes: Runs both burst orders with random words and start addresses.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [15:0] addr = 16'h0;
    logic [15:0] base = 16'h0;
    logic ps_n = 1'b1;
    logic cs_n = 1'b1;
    logic step_n = 1'b1;
    logic wr_n = 1'b1;
    logic oe_n = 1'b1;
    logic sleep = 1'b0;
    logic mode = 1'b0;
    logic h_oe = 1'b0;
    logic [31:0] h_data = 32'h0;
    logic [31:0] seed = 32'h3e;
    pbsp_pkg::pbsp_sel_t sel = 3'h2;
    logic [31:0] dq_o, dq_in;
    logic dq_oe, sleeping, wr_ready, strap;
    logic [31:0] mem [int];
    logic [4:0] bad [5] = '{5'h16, 5'h10, 5'h13, 5'h0e, 5'h06};
    int mismatches = 0;
    int checks = 0;
    int cycles = 0;
    always #4 clk = ~clk;
    pbsp_top i_dut (.ref_clk_i(clk), .reset_n_i(rst_n), .addr_i(addr),
        .proc_addr_strobe_n_i(ps_n), .ctrl_addr_strobe_n_i(cs_n), .burst_step_n_i(step_n),
        .chip_sel_i(sel), .write_n_i(wr_n), .out_en_n_i(oe_n), .sleep_request_i(sleep),
        .burst_mode_i(strap), .dq_i(dq_in), .dq_o(dq_o), .dq_oe_o(dq_oe),
        .sleeping_o(sleeping), .wr_ready_o(wr_ready));
    pbsp_host_model i_host (.clk_i(clk), .rst_n_i(rst_n), .mode_i(mode), .dev_data_i(dq_o),
        .dev_oe_i(dq_oe), .host_oe_i(h_oe), .host_data_i(h_data), .wire_o(dq_in),
        .strap_o(strap));
    // ****
    // Helpers
    // ****
    task automatic tick();
        @(posedge clk);
        #1;
    endtask : tick
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    // Address of the k-th word of a burst that starts at a.
    function automatic logic [15:0] baddr(logic [15:0] a, logic [1:0] k, logic m);
        return {a[15:2], m ? a[1:0] ^ k : a[1:0] + k};
    endfunction : baddr
    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // One strobe cycle, then the strobes go idle with the device selected.
    task automatic strobe(logic p, logic c, pbsp_pkg::pbsp_sel_t s, logic [15:0] a, logic w);
        tick();
        {ps_n, cs_n, sel, addr, wr_n} = {p, c, s, a, w};
        tick();
        {ps_n, cs_n, sel} = {2'b11, 3'h2};
    endtask : strobe
    task automatic desel();
        strobe(1'b1, 1'b0, 3'h0, base, 1'b1);
        repeat (2) tick();
    endtask : desel
    // Single write; the host drives the word in the cycle after the strobe.
    task automatic wr(logic [15:0] a, logic [31:0] d);
        oe_n = 1'b1;
        strobe(1'b1, 1'b0, 3'h2, a, 1'b0);
        {h_oe, h_data} = {1'b1, d};
        tick();
        {h_oe, wr_n} = 2'b01;
        mem[a] = d;
    endtask : wr
    // Four-word burst read; the step input is active low.
    task automatic rd(logic [15:0] a);
        int k = 0;
        oe_n = 1'b0;
        strobe(1'b0, 1'b1, 3'h2, a, 1'b1);
        step_n = 1'b0;
        repeat (3) tick();
        step_n = 1'b1;
        chk("first read mask", 0, dq_oe);
        for (int n = 0; n < 12 && k < 4; n++) begin
            if (dq_oe === 1'b1) begin
                chk("read word", mem[baddr(a, k[1:0], mode)], dq_o);
                k++;
            end
            tick();
        end
        chk("burst words", 4, k);
    endtask : rd
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_sim
    // Cuts a hang short.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            end_sim();
        end
    end
    // ****
    // Main sequence
    // ****
    initial begin
        for (int p = 0; p < 2; p++) begin
            rst_n = 1'b0;
            mode = p[0];
            repeat (10) tick();
            rst_n = 1'b1;
            repeat (3) tick();
            base = 16'(rnd());
            for (int k = 0; k < 4; k++) wr({base[15:2], k[1:0]}, rnd());
            chk("write ready", 1, wr_ready);
            desel();
            rd(base);
            desel();
            sleep = 1'b1;
            repeat (6) tick();
            chk("sleep state", 1, sleeping);
            sleep = 1'b0;
            repeat (6) tick();
            chk("awake state", 0, sleeping);
            desel();
            rd({base[15:2], 2'h3});
            // Refused starts must leave the pins released.
            foreach (bad[i]) begin
                desel();
                strobe(bad[i][4], bad[i][3], bad[i][2:0], base, 1'b1);
                repeat (6) tick();
                chk("refused start", 0, dq_oe);
            end
            desel();
            oe_n = 1'b1;
            strobe(1'b0, 1'b1, 3'h2, base, 1'b1);
            repeat (6) tick();
            chk("pins released", 0, dq_oe);
            oe_n = 1'b0;
            repeat (5) tick();
            chk("pins driven", 1, dq_oe);
            desel();
        end
        end_sim();
    end
endmodule : tb_top
`default_nettype wire
